// file: pkg/spm_pkg.sv
// spm_pkg: constants shared by the serial poll master and its memory
// assumes a 125 MHz single clock domain; no software registers exist
package spm_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ           = 125;   // core clock rate
  localparam int RESP_TIMEOUT_US   = 1000;  // default response timeout
  localparam int DIAG_INTERVAL_US  = 500;   // default diagnose repeat
  localparam int RESP_TIMEOUT_CYC  = RESP_TIMEOUT_US * CLK_MHZ;
  localparam int DIAG_INTERVAL_CYC = DIAG_INTERVAL_US * CLK_MHZ;
  localparam int TMR_W             = 32;    // timer counter width

  // ----------------------------------------------------------------
  // slave addressing
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_BCAST    = 8'h00;  // broadcast
  localparam logic [7:0] ADDR_MIN      = 8'h01;  // first slave id
  localparam logic [7:0] ADDR_MAX      = 8'hF7;  // last slave id (247)

  // ----------------------------------------------------------------
  // failure tracking and diagnose packet
  // ----------------------------------------------------------------
  localparam logic [1:0] MISS_LIMIT    = 2'h3;   // unanswered to diag
  localparam logic [7:0] DIAG_LEN      = 8'h03;  // diagnose length byte
  localparam logic [1:0] DIAG_BYTES    = 2'h3;   // bytes per packet
  localparam int         FAULT_DEPTH   = 16;     // fault location slots
  localparam int         FAULT_AW      = 4;      // slot index width

  // ----------------------------------------------------------------
  // master state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPM_IDLE,       // ready for a request
    SPM_SEND,       // request bytes leaving
    SPM_WAIT,       // waiting for slave reply
    SPM_DIAG_WAIT,  // diagnostic mode, timing the interval
    SPM_DIAG_SEND   // diagnostic mode, emitting packet
  } spm_state_e;

endpackage : spm_pkg

// file: logic/spm_fault_mem.sv
// spm_fault_mem: small store of fault locations (page, module)
// assumes writes and reads on the same clock; read data registered
`timescale 1ns/10ps
module spm_fault_mem
(
  input  wire logic                        CLK,     // core clock
  input  wire logic                        we,      // write strobe
  input  wire logic [spm_pkg::FAULT_AW-1:0] waddr,  // write slot
  input  wire logic [15:0]                 wdata,   // {page, module}
  input  wire logic [spm_pkg::FAULT_AW-1:0] raddr,  // read slot
  output logic      [15:0]                 rdata    // registered read
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] mem_reg [spm_pkg::FAULT_DEPTH];  // no reset, data only

  // write port
  always_ff @(posedge CLK)
  begin
    if (we)
    begin
      mem_reg[waddr] <= wdata;
    end
  end

  // read port, one cycle latency
  always_ff @(posedge CLK)
  begin
    rdata <= mem_reg[raddr];
  end

endmodule // spm_fault_mem

// file: logic/spm_master.sv
// spm_master: serial poll master with timeout and diagnostic mode
// assumes a byte transmitter on TX_* and a frame checker on RX_* that
// pulse on a whole checked reply; both on CLK, so no synchronisers
`timescale 1ns/10ps

module spm_master
#(
  parameter int RESP_TIMEOUT_CYC  = spm_pkg::RESP_TIMEOUT_CYC,
  parameter int DIAG_INTERVAL_CYC = spm_pkg::DIAG_INTERVAL_CYC
)
(
  input  wire logic        CLK,         // core clock
  input  wire logic        RESETN,      // async reset, active low
  input  wire logic        REQ_VALID,   // user request offered
  output logic             REQ_READY,   // request taken this cycle if valid
  input  wire logic [7:0]  REQ_ADDR,    // target slave address
  input  wire logic [7:0]  REQ_FUNC,    // function code byte
  input  wire logic [3:0]  REQ_SLOT,    // fault slot of this request
  input  wire logic [15:0] REQ_LOC,     // {page, module} of the slot
  output logic             REQ_REFUSED, // reserved address, pulse
  output logic             TX_VALID,    // byte offered to line
  input  wire logic        TX_READY,    // line takes byte
  output logic [7:0]       TX_DATA,     // byte on line
  output logic             TX_DIAG,     // byte is diagnose packet
  input  wire logic        RX_DONE,     // whole checked reply, pulse
  input  wire logic        RX_EXCEPT,   // reply is an exception
  output logic             RSP_OK,      // normal reply, pulse
  output logic             RSP_EXCEPT,  // exception reply, pulse
  output logic             RSP_TIMEOUT, // request abandoned, pulse
  output logic             DIAG_MODE    // diagnostic mode level
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  spm_pkg::spm_state_e state_reg;          // master state
  logic [spm_pkg::TMR_W-1:0] tmr_reg;      // timeout / interval timer
  logic [1:0]  miss_reg;                   // unanswered count
  logic [1:0]  byte_reg;                   // byte index in frame
  logic [7:0]  addr_reg;                   // latched address
  logic [7:0]  func_reg;                   // latched function
  logic [3:0]  slot_reg;                   // slot of last request
  logic        bcast_reg;                  // request was broadcast
  logic [15:0] loc_rd;                     // fault location read back
  logic        take;                       // request accepted
  logic        tx_fire;                    // byte handed over
  logic        timed_out;                  // timer reached limit

  // legal target test, used by accept and refusal
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a <= spm_pkg::ADDR_MAX);
  endfunction

  // ----------------------------------------------------------------
  // handshakes
  // ----------------------------------------------------------------
  // requests only taken in idle, so one is ever outstanding
  assign REQ_READY = (state_reg == spm_pkg::SPM_IDLE)
                   && addr_ok(REQ_ADDR);
  assign take      = REQ_VALID && REQ_READY;
  assign tx_fire   = TX_VALID && TX_READY;
  assign timed_out = (tmr_reg == 32'(RESP_TIMEOUT_CYC - 1));
  assign TX_VALID  = (state_reg == spm_pkg::SPM_SEND)
                   || (state_reg == spm_pkg::SPM_DIAG_SEND);
  assign TX_DIAG   = (state_reg == spm_pkg::SPM_DIAG_SEND);
  assign DIAG_MODE = TX_DIAG || (state_reg == spm_pkg::SPM_DIAG_WAIT);

  // transmit byte mux; diag bytes are length, page, module
  always_comb
  begin
    if (TX_DIAG)
    begin
      case (byte_reg)
        2'h0:    TX_DATA = spm_pkg::DIAG_LEN;
        2'h1:    TX_DATA = loc_rd[15:8];
        default: TX_DATA = loc_rd[7:0];
      endcase
    end
    else
    begin
      TX_DATA = (byte_reg == 2'h0) ? addr_reg : func_reg;
    end
  end

  // fault location of the last request, registered read
  spm_fault_mem u_mem
  (
    .CLK   (CLK),
    .we    (take),
    .waddr (REQ_SLOT),
    .wdata (REQ_LOC),
    .raddr (slot_reg),
    .rdata (loc_rd)
  );

  // ----------------------------------------------------------------
  // master sequence
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      state_reg <= spm_pkg::SPM_IDLE;
      byte_reg  <= 2'h0;
    end
    else
    begin
      case (state_reg)
        spm_pkg::SPM_IDLE:
        begin
          if (take)
          begin
            state_reg <= spm_pkg::SPM_SEND;
            byte_reg  <= 2'h0;
          end
        end
        spm_pkg::SPM_SEND:
        begin
          if (tx_fire)
          begin
            byte_reg <= byte_reg + 2'h1;
            if (byte_reg == 2'h1)
            begin
              byte_reg <= 2'h0;
              // broadcast: nothing comes back, free at once
              state_reg <= bcast_reg ? spm_pkg::SPM_IDLE
                                     : spm_pkg::SPM_WAIT;
            end
          end
        end
        spm_pkg::SPM_WAIT:
        begin
          if (RX_DONE)
          begin
            state_reg <= spm_pkg::SPM_IDLE;
          end
          else if (timed_out)
          begin
            // third straight miss switches to diagnosis
            state_reg <= (miss_reg == spm_pkg::MISS_LIMIT - 2'h1)
                       ? spm_pkg::SPM_DIAG_SEND
                       : spm_pkg::SPM_IDLE;
          end
        end
        spm_pkg::SPM_DIAG_SEND:
        begin
          if (RX_DONE && !RX_EXCEPT)
          begin
            state_reg <= spm_pkg::SPM_IDLE;
            byte_reg  <= 2'h0;
          end
          else if (tx_fire)
          begin
            byte_reg <= byte_reg + 2'h1;
            if (byte_reg == spm_pkg::DIAG_BYTES - 2'h1)
            begin
              byte_reg  <= 2'h0;
              state_reg <= spm_pkg::SPM_DIAG_WAIT;
            end
          end
        end
        spm_pkg::SPM_DIAG_WAIT:
        begin
          if (RX_DONE && !RX_EXCEPT)
          begin
            state_reg <= spm_pkg::SPM_IDLE;
          end
          else if (tmr_reg == 32'(DIAG_INTERVAL_CYC - 1))
          begin
            state_reg <= spm_pkg::SPM_DIAG_SEND;
          end
        end
        default:
        begin
          state_reg <= spm_pkg::SPM_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // timer: counts only while waiting, cleared elsewhere
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tmr_reg <= '0;
    end
    else if ((state_reg == spm_pkg::SPM_WAIT && !timed_out)
          || (state_reg == spm_pkg::SPM_DIAG_WAIT
              && tmr_reg != 32'(DIAG_INTERVAL_CYC - 1)))
    begin
      tmr_reg <= tmr_reg + 32'h1;
    end
    else
    begin
      tmr_reg <= '0;
    end
  end

  // ----------------------------------------------------------------
  // unanswered counter; a correct reply clears it outside idle and send
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      miss_reg <= 2'h0;
    end
    else if (RX_DONE && !RX_EXCEPT && state_reg != spm_pkg::SPM_IDLE
          && state_reg != spm_pkg::SPM_SEND)
    begin
      miss_reg <= 2'h0;
    end
    else if (state_reg == spm_pkg::SPM_WAIT && timed_out && !RX_DONE)
    begin
      // saturate at the limit; diagnosis keeps it there
      miss_reg <= (miss_reg == spm_pkg::MISS_LIMIT) ? miss_reg
                : miss_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // request latch
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      addr_reg  <= 8'h00;
      func_reg  <= 8'h00;
      slot_reg  <= 4'h0;
      bcast_reg <= 1'b0;
    end
    else if (take)
    begin
      addr_reg  <= REQ_ADDR;
      func_reg  <= REQ_FUNC;
      slot_reg  <= REQ_SLOT;
      bcast_reg <= (REQ_ADDR == spm_pkg::ADDR_BCAST);
    end
  end

  // ----------------------------------------------------------------
  // result pulses; replies outside a wait are stray, dropped
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      RSP_OK      <= 1'b0;
      RSP_EXCEPT  <= 1'b0;
      RSP_TIMEOUT <= 1'b0;
      REQ_REFUSED <= 1'b0;
    end
    else
    begin
      RSP_OK      <= (state_reg == spm_pkg::SPM_WAIT) && RX_DONE
                   && !RX_EXCEPT;
      RSP_EXCEPT  <= (state_reg == spm_pkg::SPM_WAIT) && RX_DONE
                   && RX_EXCEPT;
      RSP_TIMEOUT <= (state_reg == spm_pkg::SPM_WAIT) && timed_out
                   && !RX_DONE;
      REQ_REFUSED <= REQ_VALID && (state_reg == spm_pkg::SPM_IDLE)
                   && !addr_ok(REQ_ADDR);
    end
  end

endmodule // spm_master

// file: dv/spm_master_chk.sv
// spm_master_chk: port-level assertions for the serial poll master
// assumes it is bound onto spm_master; one clock, async low reset
`timescale 1ns/10ps
module spm_master_chk
#(
  parameter int RESP_TIMEOUT_CYC  = 20,  // wait before giving up
  parameter int DIAG_INTERVAL_CYC = 10   // diagnose repeat period
)
(
  input wire logic       CLK,
  input wire logic       RESETN,
  input wire logic       REQ_VALID,
  input wire logic       REQ_READY,
  input wire logic [7:0] REQ_ADDR,
  input wire logic       REQ_REFUSED,
  input wire logic       TX_VALID,
  input wire logic       TX_READY,
  input wire logic [7:0] TX_DATA,
  input wire logic       TX_DIAG,
  input wire logic       RX_DONE,
  input wire logic       RX_EXCEPT,
  input wire logic       RSP_OK,
  input wire logic       RSP_EXCEPT,
  input wire logic       RSP_TIMEOUT,
  input wire logic       DIAG_MODE
);
  // ----------------------------------------------------------------
  // helper: cycles since the last byte left for the line
  // ----------------------------------------------------------------
  int quiet_reg;  // never wraps within a short run
  always_ff @(posedge CLK or negedge RESETN)
    if (!RESETN)
      quiet_reg <= 0;
    else
      quiet_reg <= (TX_VALID && TX_READY) ? 0 : quiet_reg + 1;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  ready_addr_a: assert property (REQ_READY |-> REQ_ADDR <= 8'hF7)
    else $error("request accepted with a reserved address");
  refuse_cause_a: assert property (REQ_REFUSED |->
    $past(REQ_VALID && REQ_ADDR >= 8'hF8))
    else $error("refusal without a reserved address");
  take_addr_a: assert property (REQ_VALID && REQ_READY |=>
    TX_VALID && !TX_DIAG && TX_DATA == $past(REQ_ADDR))
    else $error("address byte not first on the line");
  busy_hold_a: assert property (TX_VALID || DIAG_MODE |-> !REQ_READY)
    else $error("new request taken while busy");
  tx_stable_a: assert property (TX_VALID && !TX_READY
    && !(TX_DIAG && RX_DONE && !RX_EXCEPT) |=>
    TX_VALID && $stable(TX_DATA) && $stable(TX_DIAG))
    else $error("stalled byte dropped or changed");
  tmo_span_a: assert property (RSP_TIMEOUT |->
    quiet_reg >= RESP_TIMEOUT_CYC - 1 && quiet_reg <= RESP_TIMEOUT_CYC + 2)
    else $error("timeout at the wrong moment");
  reply_kind_a: assert property (RSP_OK || RSP_EXCEPT |->
    $past(RX_DONE) && RSP_EXCEPT == $past(RX_EXCEPT) && !RSP_TIMEOUT)
    else $error("reply pulse not matching the reply");
  diag_quiet_a: assert property (DIAG_MODE |-> !RSP_OK && !RSP_EXCEPT)
    else $error("reply pulse during diagnostic mode");
  diag_first_a: assert property ($rose(DIAG_MODE) |->
    TX_VALID && TX_DIAG && TX_DATA == 8'h03)
    else $error("diagnose packet not led by its length");
  diag_gap_a: assert property ($fell(TX_VALID) && $past(TX_DIAG) |->
    (!TX_VALID || !DIAG_MODE) [*8])
    else $error("diagnose packets repeat too soon");
  diag_exit_a: assert property (DIAG_MODE && RX_DONE && !RX_EXCEPT |=>
    !DIAG_MODE)
    else $error("correct reply did not end diagnostic mode");
endmodule // spm_master_chk

bind spm_master spm_master_chk #(
  .RESP_TIMEOUT_CYC (RESP_TIMEOUT_CYC),
  .DIAG_INTERVAL_CYC(DIAG_INTERVAL_CYC)
) chk_u (.CLK, .RESETN, .REQ_VALID, .REQ_READY, .REQ_ADDR, .REQ_REFUSED,
  .TX_VALID, .TX_READY, .TX_DATA, .TX_DIAG, .RX_DONE, .RX_EXCEPT,
  .RSP_OK, .RSP_EXCEPT, .RSP_TIMEOUT, .DIAG_MODE);

// file: dv/spm_slave_model.sv
// spm_slave_model: serial slave on the far side of the poll master
// assumes whole checked replies are signalled as one RX_DONE pulse
`timescale 1ns/10ps
module spm_slave_model
(
  input  wire logic       CLK,
  input  wire logic       RESETN,
  input  wire logic       TX_VALID,
  input  wire logic [7:0] TX_DATA,
  input  wire logic       TX_DIAG,
  input  wire logic       answer,     // slave alive
  input  wire logic       except_on,  // reply with an exception
  input  wire logic       stall,      // line busy this cycle
  output logic            TX_READY,
  output logic            RX_DONE,
  output logic            RX_EXCEPT
);
  int         nb;    // byte index in frame
  int         dly;   // reply countdown, 0 idle
  logic [7:0] addr;  // addressed slave of this frame
  assign TX_READY = !stall;
  // replies only after a whole frame; qualifier churns when unused
  always @(posedge CLK or negedge RESETN)
    if (!RESETN)
    begin
      nb <= 0;
      dly <= 0;
      addr <= 8'h00;
      RX_DONE <= 1'b0;
      RX_EXCEPT <= 1'b0;
    end
    else
    begin
      RX_DONE <= (dly == 1);
      RX_EXCEPT <= (dly == 1) ? except_on : ~RX_EXCEPT;
      if (dly > 0) dly <= dly - 1;
      if (TX_VALID && TX_READY)
      begin
        if (nb == 0) addr <= TX_DATA;
        nb <= (nb == (TX_DIAG ? 2 : 1)) ? 0 : nb + 1;
        if (nb == (TX_DIAG ? 2 : 1) && answer && (TX_DIAG || addr != 8'h00))
          dly <= 3;
      end
    end
endmodule // spm_slave_model

// file: dv/spm_master_tb.sv
// spm_master_tb: self-checking bench for the serial poll master
// assumes the slave model on the line and short timer parameters
`timescale 1ns/10ps
module spm_master_tb;
  logic        CLK = 0, RESETN = 0, REQ_VALID = 0, REQ_READY, REQ_REFUSED;
  logic [7:0]  REQ_ADDR = 8'h01, REQ_FUNC = 8'h03, TX_DATA;
  logic [3:0]  REQ_SLOT = 4'h0;
  logic [15:0] REQ_LOC = 16'h0000, last_loc;
  logic        TX_VALID, TX_READY, TX_DIAG, RX_DONE, RX_EXCEPT;
  logic        RSP_OK, RSP_EXCEPT, RSP_TIMEOUT, DIAG_MODE;
  logic        answer = 0, except_on = 0, stall = 0;
  logic [31:0] lfsr = 32'h0001_2A71;  // fixed seed, 76401
  logic [8:0]  exp_q[$];          // expected {diag, byte} on the line
  int          error_cnt = 0, compares = 0, cyc = 0, n;

  // short timers keep every timeout and interval inside the run
  spm_master #(.RESP_TIMEOUT_CYC(20), .DIAG_INTERVAL_CYC(10)) dut_u
  (
    .CLK(CLK), .RESETN(RESETN), .REQ_VALID(REQ_VALID),
    .REQ_READY(REQ_READY), .REQ_ADDR(REQ_ADDR), .REQ_FUNC(REQ_FUNC),
    .REQ_SLOT(REQ_SLOT), .REQ_LOC(REQ_LOC), .REQ_REFUSED(REQ_REFUSED),
    .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_DATA(TX_DATA),
    .TX_DIAG(TX_DIAG), .RX_DONE(RX_DONE), .RX_EXCEPT(RX_EXCEPT),
    .RSP_OK(RSP_OK), .RSP_EXCEPT(RSP_EXCEPT), .RSP_TIMEOUT(RSP_TIMEOUT),
    .DIAG_MODE(DIAG_MODE)
  );
  // slave side of the line, answers whole frames
  spm_slave_model slv_u
  (
    .CLK(CLK), .RESETN(RESETN), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
    .TX_DIAG(TX_DIAG), .answer(answer), .except_on(except_on),
    .stall(stall), .TX_READY(TX_READY), .RX_DONE(RX_DONE),
    .RX_EXCEPT(RX_EXCEPT)
  );

  always #4 CLK = ~CLK;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // next value of the stimulus shift register
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // random line stalls, stimulus shift register advanced every cycle
  always @(posedge CLK)
  begin
    #1;
    lfsr = lfsr_next(lfsr);
    stall = lfsr[0] & lfsr[3];
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      summarize();
    end
  end

  // every byte that leaves is compared with the bench's expected queue
  always @(posedge CLK)
    if (RESETN && TX_VALID && TX_READY)
      chk("line byte", {TX_DIAG, TX_DATA},
          exp_q.size() ? exp_q.pop_front() : 9'h1FF);

  // one request; outcome 0 ok, 1 exception, 2 timeout, 3 diag, 4 none
  task automatic req(logic [7:0] a, int code);
    int got;
    REQ_ADDR = a;
    REQ_FUNC = lfsr[15:8];
    REQ_SLOT = lfsr[19:16];
    REQ_LOC = lfsr[31:16];
    REQ_VALID = 1;
    n = 0;
    #1;
    while (REQ_READY !== 1'b1 && n < 100)
    begin
      @(posedge CLK);
      #1;
      n++;
    end
    exp_q.push_back({1'b0, a});
    exp_q.push_back({1'b0, REQ_FUNC});
    last_loc = REQ_LOC;
    @(posedge CLK);
    #1;
    REQ_VALID = 0;
    got = 4;
    n = 0;
    while (n < 40 && got == 4)
    begin
      @(posedge CLK);
      #1;
      n++;
      if (DIAG_MODE === 1'b1) got = 3;
      else if (RSP_OK === 1'b1) got = 0;
      else if (RSP_EXCEPT === 1'b1) got = 1;
      else if (RSP_TIMEOUT === 1'b1) got = 2;
    end
    chk("outcome", 16'(got), 16'(code));
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge CLK);
    #1 RESETN = 1;
    answer = 1;
    req(8'h01, 0);
    req(8'hF7, 0);
    except_on = 1;
    req(8'h05, 1);
    except_on = 0;
    req(8'h00, 4);
    chk("ready after broadcast", REQ_READY, 1);
    // valid held up across the sweep, address moves each cycle
    REQ_VALID = 1;
    for (int a = 248; a < 256; a++)
    begin
      REQ_ADDR = 8'(a);
      @(posedge CLK);
      #1;
      chk("refused", {REQ_REFUSED, REQ_READY}, 2'h2);
    end
    REQ_VALID = 0;
    @(posedge CLK);
    #1;
    chk("refusal ends", REQ_REFUSED, 1'b0);
    answer = 0;
    req(8'h02, 2);
    req(8'h03, 2);
    answer = 1;
    req(8'h04, 0);
    answer = 0;
    req(8'h06, 2);
    req(8'h07, 2);
    req(8'h08, 3);
    repeat (3)
    begin
      exp_q.push_back(9'h103);
      exp_q.push_back({1'b1, last_loc[15:8]});
      exp_q.push_back({1'b1, last_loc[7:0]});
    end
    // exception replies to the second packet must not end diagnosis
    for (n = 0; n < 300 && exp_q.size() > 6; n++) @(posedge CLK);
    #1;
    answer = 1;
    except_on = 1;
    for (n = 0; n < 300 && exp_q.size() > 3; n++) @(posedge CLK);
    repeat (6) @(posedge CLK);
    #1;
    except_on = 0;
    chk("diag held", DIAG_MODE, 1'b1);
    for (n = 0; n < 300 && DIAG_MODE !== 1'b0; n++) @(posedge CLK);
    #1;
    chk("diag left", {DIAG_MODE, 8'(exp_q.size())}, 9'h000);
    req(8'h09, 0);
    summarize();
  end
endmodule // spm_master_tb
